// >>> logic/dfc_pkg.sv
`default_nettype none
package dfc_pkg;

   // core clock
   localparam int CLK_HZ = 25_000_000;

   // register indices; the byte address is four times the index
   localparam logic [7:0] DIM_IDX   = 8'h7E;
   localparam logic [7:0] RSVD_IDX  = 8'h7F;
   localparam logic [7:0] FSMAP_IDX = 8'h80;
   localparam logic [11:0] DIM_ADDR   = {2'b00, DIM_IDX, 2'b00};
   localparam logic [11:0] RSVD_ADDR  = {2'b00, RSVD_IDX, 2'b00};
   localparam logic [11:0] FSMAP_ADDR = {2'b00, FSMAP_IDX, 2'b00};

   // dimming configuration field positions
   localparam int EXP_BIT   = 7;
   localparam int PHASE_BIT = 6;
   localparam int RES_BIT   = 5;
   localparam int SAVE_BIT  = 4;
   localparam int FREQ_MSB  = 3;
   localparam int FREQ_LSB  = 0;

   // fail-safe map layout: group a in bits 2..0, group b in bits 6..4
   localparam int NUM_OUT      = 6;
   localparam int GRP_A_LSB    = 0;
   localparam int GRP_B_LSB    = 4;
   localparam logic [7:0] MAP_WR_MASK = 8'h77;

   // reset values
   localparam logic [7:0] DIM_RESET   = 8'h00;
   localparam logic [7:0] RSVD_RESET  = 8'h00;
   localparam logic [7:0] FSMAP_RESET = 8'h00;

   // pwm frequency per code in Hz; code Eh repeats the next lower entry
   localparam int FREQ_HZ [16] = '{200, 250, 300, 350, 400, 500, 600, 800,
                                   1000, 1200, 2000, 4000, 5900, 7800, 7800, 20800};
   localparam int PERIOD_W = 17;

   typedef enum logic {DFC_LOAD, DFC_RUN} dfc_state_t;

   // pwm period in core cycles, rounded down
   function automatic logic [PERIOD_W-1:0] dfc_period_of(input logic [3:0] code);
      return PERIOD_W'(CLK_HZ / FREQ_HZ[code]);
   endfunction

endpackage
`default_nettype wire

// >>> logic/dfc_failsafe_route.sv
`timescale 1ns/1ps
`default_nettype none
module dfc_failsafe_route
   import dfc_pkg::*;
(
   input  wire logic               clk,
   input  wire logic               rst_b,
   input  wire logic               failsafe_active,
   input  wire logic [NUM_OUT-1:0] map_bits,
   input  wire logic [NUM_OUT-1:0] normal_drive,
   input  wire logic               failsafe_input_first,
   input  wire logic               failsafe_input_second,
   output logic      [NUM_OUT-1:0] out_drive
);

   logic [1:0] fs_meta_reg;
   logic [1:0] fs_sync_reg;

   // two-flop synchroniser for the pin inputs
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fs_meta_reg <= 2'h0;
         fs_sync_reg <= 2'h0;
      end else begin
         fs_meta_reg <= {failsafe_input_second, failsafe_input_first};
         fs_sync_reg <= fs_meta_reg;
      end
   end

   genvar i;
   generate
      for (i = 0; i < NUM_OUT; i++) begin : g_out
         always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
               out_drive[i] <= 1'b0;
            // R10: map selects input
            end else if (failsafe_active) begin
               out_drive[i] <= map_bits[i] ? fs_sync_reg[1] : fs_sync_reg[0];
            // R11: normal drive passes
            end else begin
               out_drive[i] <= normal_drive[i];
            end
         end
      end
   endgenerate

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_fs_route_sel: assert property ( // R10
      failsafe_active |=> out_drive == (($past(map_bits) & {NUM_OUT{$past(fs_sync_reg[1])}})
                         | (~$past(map_bits) & {NUM_OUT{$past(fs_sync_reg[0])}})))
      else $error("fail-safe output does not follow its mapped input");

   chk_normal_pass: assert property ( // R11
      !failsafe_active |=> out_drive == $past(normal_drive))
      else $error("output does not follow normal drive outside fail-safe");

   cov_fs_second: cover property (failsafe_active && map_bits[0] ##1 out_drive[0]);

endmodule // dfc_failsafe_route
`default_nettype wire

// >>> logic/dfc_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1: after every reset the dimming and mapping fields load from the stored nonvolatile image.
// R2: dimming bit 7 selects the exponential curve when 1 and the linear curve when 0.
// R3: dimming bit 6 enables phase-shifted pwm between outputs when 1.
// R4: dimming bit 5 enables the 12-bit dimming resolution when 1.
// R5: dimming bit 4 turns digital power save on when 1.
// R6: dimming bits 3..0 pick the pwm frequency from 200 Hz at 0h up to 20800 Hz at Fh.
// R7: the unlisted code Eh keeps the next lower frequency, 7800 Hz.
// R8: the register at 7Fh is fully reserved, resets to 00h and always reads zero.
// R9: the map at 80h holds a0..a2 in bits 0..2 and b0..b2 in bits 4..6, bits 3 and 7 read zero.
// R10: in fail-safe an output with map bit 0 follows the first input, with 1 the second.
// R11: outside fail-safe the map has no effect and outputs follow their normal drive.
module dfc_regs
   import dfc_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst_b,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic [7:0]          nv_dimming_config,
   input  wire logic [7:0]          nv_failsafe_map,
   input  wire logic                failsafe_active,
   input  wire logic                failsafe_input_first,
   input  wire logic                failsafe_input_second,
   input  wire logic                normal_a_zero,
   input  wire logic                normal_a_one,
   input  wire logic                normal_a_two,
   input  wire logic                normal_b_zero,
   input  wire logic                normal_b_one,
   input  wire logic                normal_b_two,
   output logic                     exponential_curve_enable,
   output logic                     phase_shift_enable,
   output logic                     twelve_bit_resolution_enable,
   output logic                     power_save_enable,
   output logic      [3:0]          dimming_frequency_code,
   output logic      [PERIOD_W-1:0] pwm_period_cycles,
   output logic                     config_loaded,
   output logic                     group_a_output_zero,
   output logic                     group_a_output_one,
   output logic                     group_a_output_two,
   output logic                     group_b_output_zero,
   output logic                     group_b_output_one,
   output logic                     group_b_output_two
);

   dfc_state_t          state_reg;
   logic [7:0]          dimming_config_reg;
   logic [7:0]          failsafe_map_groups_a_b_reg;
   logic [31:0]         prdata_reg;
   logic                pslverr_reg;
   logic [PERIOD_W-1:0] period_reg;
   logic [31:0]         rdata_next;
   logic                err_next;
   logic                wr_go;
   logic [NUM_OUT-1:0]  map_bits;
   logic [NUM_OUT-1:0]  normal_drive;
   logic [NUM_OUT-1:0]  out_drive;

   // load state: one cycle after reset release copies the stored image
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= DFC_LOAD;
      end else begin
         case (state_reg)
            DFC_LOAD: state_reg <= DFC_RUN;
            DFC_RUN:  state_reg <= DFC_RUN;
            default:  state_reg <= DFC_LOAD;
         endcase
      end
   end

   // bus stalls until the stored image is in place
   assign pready  = (state_reg == DFC_RUN);
   assign wr_go   = psel && penable && pready && pwrite;
   assign prdata  = prdata_reg;
   assign pslverr = pslverr_reg;

   // dimming configuration register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dimming_config_reg <= DIM_RESET;
      // R1: load dimming image
      end else if (state_reg == DFC_LOAD) begin
         dimming_config_reg <= nv_dimming_config;
      end else if (wr_go && paddr == DIM_ADDR) begin
         dimming_config_reg <= pwdata[7:0];
      end
   end

   // fail-safe map register
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         failsafe_map_groups_a_b_reg <= FSMAP_RESET;
      // R1: load map image
      end else if (state_reg == DFC_LOAD) begin
         failsafe_map_groups_a_b_reg <= nv_failsafe_map & MAP_WR_MASK;
      // R9: reserved bits held zero
      end else if (wr_go && paddr == FSMAP_ADDR) begin
         failsafe_map_groups_a_b_reg <= pwdata[7:0] & MAP_WR_MASK;
      end
   end

   // read mux and error decode
   always_comb begin
      rdata_next = 32'h0000_0000;
      err_next   = 1'b0;
      if (paddr == DIM_ADDR) begin
         rdata_next = {24'h00_0000, dimming_config_reg};
      // R8: reserved register reads zero
      end else if (paddr == RSVD_ADDR) begin
         rdata_next = {24'h00_0000, RSVD_RESET};
      end else if (paddr == FSMAP_ADDR) begin
         rdata_next = {24'h00_0000, failsafe_map_groups_a_b_reg};
      end else begin
         err_next = 1'b1;
      end
   end

   // answer captured ahead of the completing edge
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (psel && !(penable && pready)) begin
         prdata_reg  <= pwrite ? 32'h0000_0000 : rdata_next;
         pslverr_reg <= err_next;
      end else begin
         prdata_reg  <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end
   end

   // R6: frequency code to pwm period
   // R7: code Eh held at 7800 Hz
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         period_reg <= dfc_period_of(DIM_RESET[FREQ_MSB:FREQ_LSB]);
      end else begin
         period_reg <= dfc_period_of(dimming_config_reg[FREQ_MSB:FREQ_LSB]);
      end
   end

   // R2: curve select
   assign exponential_curve_enable     = dimming_config_reg[EXP_BIT];
   // R3: phase shift enable
   assign phase_shift_enable           = dimming_config_reg[PHASE_BIT];
   // R4: resolution enable
   assign twelve_bit_resolution_enable = dimming_config_reg[RES_BIT];
   // R5: power save enable
   assign power_save_enable            = dimming_config_reg[SAVE_BIT];
   assign dimming_frequency_code       = dimming_config_reg[FREQ_MSB:FREQ_LSB];
   assign pwm_period_cycles            = period_reg;
   assign config_loaded                = (state_reg == DFC_RUN);

   assign map_bits = {failsafe_map_groups_a_b_reg[GRP_B_LSB +: 3],
                      failsafe_map_groups_a_b_reg[GRP_A_LSB +: 3]};
   assign normal_drive = {normal_b_two, normal_b_one, normal_b_zero,
                          normal_a_two, normal_a_one, normal_a_zero};

   // R10: per-output fail-safe routing
   // R11: normal drive outside fail-safe
   dfc_failsafe_route u_route (
      .clk                   (clk),
      .rst_b                 (rst_b),
      .failsafe_active       (failsafe_active),
      .map_bits              (map_bits),
      .normal_drive          (normal_drive),
      .failsafe_input_first  (failsafe_input_first),
      .failsafe_input_second (failsafe_input_second),
      .out_drive             (out_drive)
   );

   assign group_a_output_zero = out_drive[0];
   assign group_a_output_one  = out_drive[1];
   assign group_a_output_two  = out_drive[2];
   assign group_b_output_zero = out_drive[3];
   assign group_b_output_one  = out_drive[4];
   assign group_b_output_two  = out_drive[5];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_load_dim_image: assert property ( // R1
      state_reg == DFC_LOAD |=> dimming_config_reg == $past(nv_dimming_config)
                                && pready)
      else $error("dimming config not loaded from stored image");

   chk_load_map_image: assert property ( // R1
      state_reg == DFC_LOAD |=> failsafe_map_groups_a_b_reg
                                == ($past(nv_failsafe_map) & MAP_WR_MASK))
      else $error("fail-safe map not loaded from stored image");

   chk_map_write_mask: assert property ( // R9
      wr_go && paddr == FSMAP_ADDR |=> failsafe_map_groups_a_b_reg
                                       == ($past(pwdata[7:0]) & MAP_WR_MASK))
      else $error("fail-safe map write not masked to its mapping bits");

   chk_exp_curve_write: assert property ( // R2
      wr_go && paddr == DIM_ADDR |=> exponential_curve_enable == $past(pwdata[7]))
      else $error("curve select does not follow written bit 7");

   chk_phase_res_write: assert property ( // R3
      wr_go && paddr == DIM_ADDR |=> phase_shift_enable == $past(pwdata[6])
                                     && twelve_bit_resolution_enable == $past(pwdata[5]))
      else $error("phase shift or resolution enable does not follow write");

   chk_save_write: assert property ( // R5
      wr_go && paddr == DIM_ADDR |=> power_save_enable == $past(pwdata[4]))
      else $error("power save does not follow written bit 4");

   chk_freq_low_end: assert property ( // R6
      dimming_frequency_code == 4'h0 |=> pwm_period_cycles == 17'h1E848)
      else $error("code 0h does not give a 200 Hz period");

   chk_freq_top_end: assert property ( // R6
      dimming_frequency_code == 4'hF |=> pwm_period_cycles == 17'h004B1)
      else $error("code Fh does not give a 20800 Hz period");

   chk_freq_code_e: assert property ( // R7
      dimming_frequency_code == 4'hE |=> pwm_period_cycles == 17'h00C85)
      else $error("code Eh does not hold the 7800 Hz period");

   chk_rsvd_reads_zero: assert property ( // R8
      psel && !penable && !pwrite && paddr == RSVD_ADDR
      ##1 psel && penable && pready |-> prdata == 32'h0000_0000 && !pslverr)
      else $error("reserved register read is not zero");

   chk_map_rsvd_bits: assert property ( // R9
      psel && !penable && !pwrite && paddr == FSMAP_ADDR
      ##1 psel && penable && pready |-> prdata[7] == 1'b0 && prdata[3] == 1'b0
                                        && prdata[31:8] == 24'h00_0000)
      else $error("map reserved bits do not read zero");

   cov_dim_write: cover property (wr_go && paddr == DIM_ADDR && pwdata[7]);
   cov_map_read: cover property (psel && penable && pready && !pwrite
                                 && paddr == FSMAP_ADDR && prdata[6]);
   cov_unmapped: cover property (psel && penable && pready && pslverr);
   cov_code_e: cover property (dimming_frequency_code == 4'hE);

endmodule // dfc_regs
`default_nettype wire

// >>> verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dfc_pkg::*;
   logic                clk = 1'b0;
   logic                rst_b = 1'b0;
   logic                psel = 1'b0;
   logic                penable = 1'b0;
   logic                pwrite = 1'b0;
   logic [11:0]         paddr = 12'h000;
   logic [31:0]         pwdata = 32'h0000_0000;
   logic [31:0]         prdata;
   logic                pready;
   logic                pslverr;
   logic [7:0]          nv_dimming_config = 8'hA3;
   logic [7:0]          nv_failsafe_map = 8'hFF;
   logic                failsafe_active = 1'b0;
   logic                failsafe_input_first = 1'b0;
   logic                failsafe_input_second = 1'b0;
   logic [5:0]          nrm = 6'h00;
   logic                exp_en, phase_en, res_en, save_en, config_loaded;
   logic [3:0]          freq_code;
   logic [PERIOD_W-1:0] period;
   logic [5:0]          outs;
   logic [31:0]         rd_v;
   logic                err_v;
   int                  fail_count = 0;
   int                  checks_done = 0;
   int                  cycles = 0;
   localparam int FREQ_TB [16] = '{200, 250, 300, 350, 400, 500, 600, 800,
                                   1000, 1200, 2000, 4000, 5900, 7800, 7800, 20800};

   dfc_regs dfc_regs_i (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .nv_dimming_config(nv_dimming_config),
      .nv_failsafe_map(nv_failsafe_map), .failsafe_active(failsafe_active),
      .failsafe_input_first(failsafe_input_first),
      .failsafe_input_second(failsafe_input_second),
      .normal_a_zero(nrm[0]), .normal_a_one(nrm[1]), .normal_a_two(nrm[2]),
      .normal_b_zero(nrm[3]), .normal_b_one(nrm[4]), .normal_b_two(nrm[5]),
      .exponential_curve_enable(exp_en), .phase_shift_enable(phase_en),
      .twelve_bit_resolution_enable(res_en), .power_save_enable(save_en),
      .dimming_frequency_code(freq_code), .pwm_period_cycles(period),
      .config_loaded(config_loaded),
      .group_a_output_zero(outs[0]), .group_a_output_one(outs[1]),
      .group_a_output_two(outs[2]), .group_b_output_zero(outs[3]),
      .group_b_output_one(outs[4]), .group_b_output_two(outs[5]));

   always #20 clk = ~clk;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp_v, input logic [31:0] got);
      checks_done++;
      if (got !== exp_v) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, exp_v, got);
      end
   endtask

   // one apb transfer; answer taken at the edge where pready is high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic do_reset(input logic [7:0] dimming_config, input logic [7:0] map);
      @(posedge clk);
      rst_b <= 1'b0;
      nv_dimming_config <= dimming_config;
      nv_failsafe_map <= map;
      repeat (5) @(posedge clk);
      chk("loaded in reset", 32'h0, {30'h0, config_loaded, pready});
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      chk("loaded", 32'h3, {30'h0, config_loaded, pready});
   endtask

   task automatic check_dim(input logic [7:0] v);
      @(negedge clk);
      chk("dim bits", {24'h0, v}, {24'h0, exp_en, phase_en, res_en, save_en, freq_code});
      apb(1'b0, DIM_ADDR, 32'h0);
      chk("dim read", {24'h0, v}, rd_v);
   endtask

   task automatic t_load(input logic [7:0] dimming_config, input logic [7:0] map);
      do_reset(dimming_config, map);
      check_dim(dimming_config);
      chk("period", 32'(CLK_HZ / FREQ_TB[dimming_config[3:0]]), 32'(period));
      apb(1'b0, FSMAP_ADDR, 32'h0);
      chk("map load", {24'h0, map & 8'h77}, rd_v);
      $display("test load %h %h done", dimming_config, map);
   endtask

   task automatic t_dim_fields();
      apb(1'b1, DIM_ADDR, 32'hFFFF_FF5A);
      check_dim(8'h5A);
      apb(1'b1, DIM_ADDR, 32'h0000_00A5);
      check_dim(8'hA5);
      apb(1'b1, DIM_ADDR, 32'h0000_0010);
      check_dim(8'h10);
      $display("test dim fields done");
   endtask

   task automatic t_freq();
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, DIM_ADDR, 32'(c));
         repeat (2) @(posedge clk);
         @(negedge clk);
         chk("freq code", 32'(c), {28'h0, freq_code});
         chk("period", 32'(CLK_HZ / FREQ_TB[c]), 32'(period));
      end
      $display("test frequency codes done");
   endtask

   task automatic t_regs();
      apb(1'b1, RSVD_ADDR, 32'h0000_00FF);
      chk("rsvd wr err", 32'h0, {31'h0, err_v});
      apb(1'b0, RSVD_ADDR, 32'h0);
      chk("rsvd read", 32'h0, rd_v);
      apb(1'b1, FSMAP_ADDR, 32'hFFFF_FFFF);
      apb(1'b0, FSMAP_ADDR, 32'h0);
      chk("map read", 32'h77, rd_v);
      apb(1'b1, 12'h204, 32'h0000_0000);
      chk("unmapped err", 32'h1, {31'h0, err_v});
      apb(1'b0, FSMAP_ADDR, 32'h0);
      chk("map kept", 32'h77, rd_v);
      apb(1'b0, 12'h000, 32'h0);
      chk("unmapped rd", 32'h0000_0000, rd_v);
      chk("unmapped rd err", 32'h0000_0001, {31'h0, err_v});
      $display("test registers done");
   endtask

   task automatic t_failsafe();
      logic [5:0] m;
      apb(1'b1, FSMAP_ADDR, 32'h0000_0035);
      m = 6'b011101;
      @(posedge clk);
      nrm <= 6'b101101;
      failsafe_active <= 1'b0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("normal outs", 32'h2D, {26'h0, outs});
      for (int k = 0; k < 2; k++) begin
         @(posedge clk);
         failsafe_active <= 1'b1;
         failsafe_input_first <= k[0];
         failsafe_input_second <= ~k[0];
         repeat (5) @(posedge clk);
         @(negedge clk);
         chk("fs outs", {26'h0, k[0] ? ~m : m}, {26'h0, outs});
      end
      @(posedge clk);
      failsafe_active <= 1'b0;
      nrm <= 6'b010010;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("normal back", 32'h12, {26'h0, outs});
      $display("test fail-safe routing done");
   endtask

   initial begin
      t_load(8'hA3, 8'hFF);
      t_dim_fields();
      t_freq();
      t_regs();
      t_failsafe();
      t_load(8'h5E, 8'h0A);
      end_sim();
   end
endmodule // testbench
`default_nettype wire
